// *** shared/mscd_map.svh ***
/*
  Constants of the serial command decoder: codes, offsets, reset values, timing.
  Assumes inclusion by bare name from the package and the design.
*/
//////////////////////////////////////////////////////////////////////////////
// Contract
// (R1) commands are 6 bits, distance two apart
// (R2) frame: select bit one, code, data byte
// (R3) every field arrives least significant bit first
// (R4) decode the eight block read codes
// (R5) decode setup, answer, window, parallel writes
// (R6) decode freeze, release, reset, start, stop, single, rearm
// (R7) block one sends setup one to four
// (R8) block two sends setup five-seven, unused
// (R9) blocks three, four send diagnostics ascending
// (R10) block five sends diag nine-eleven, identity
// (R11) block six: question, unused, stepper high, low
// (R12) block seven: diag twelve twice, answer, window
// (R13) block eight: window, request low, high, counter
// (R14) data byte ignored for data-free commands
// (R15) new read waits for frame end, replaces burst
// (R16) write loads byte at once unless frozen
// (R17) freeze rejects setup writes, release allows
// (R18) answer and window writes never frozen
// (R19) reset leaves writes released
// (R20) software reset clears setup, drivers off
// (R21) start clears output disable, stop sets
// (R22) disabled: output frames ignored, stages off
// (R23) rearm turns main relay back on
// (R24) single read address in low six bits
// (R25) unknown codes change nothing
//////////////////////////////////////////////////////////////////////////////
`ifndef MSCD_MAP_SVH
`define MSCD_MAP_SVH
// frame layout
`define FRAME_BITS 4'hF
`define UP_LAST_BIT 4'hF
`define LAST_SLOT 2'h3
// timing
`define CLK_NS 20
`define UP_BIT_NS 320
`define UP_BIT_CYC (`UP_BIT_NS / `CLK_NS)
// command codes
`define CMD_RD1 6'h03
`define CMD_RD2 6'h05
`define CMD_RD3 6'h06
`define CMD_RD4 6'h09
`define CMD_RD5 6'h0A
`define CMD_RD6 6'h0C
`define CMD_RD7 6'h2D
`define CMD_RD8 6'h2E
`define CMD_WR1 6'h0F
`define CMD_WR2 6'h11
`define CMD_WR3 6'h12
`define CMD_WR4 6'h14
`define CMD_WR5 6'h17
`define CMD_WR6 6'h18
`define CMD_WR7 6'h1B
`define CMD_FREEZE 6'h1D
`define CMD_RELEASE 6'h1E
`define CMD_SWRST 6'h21
`define CMD_START 6'h22
`define CMD_SINGLE 6'h28
`define CMD_STOP 6'h2B
`define CMD_ANSWER 6'h24
`define CMD_WINDOW 6'h30
`define CMD_PARALLEL 6'h33
`define CMD_REARM 6'h27
// apb offsets and reset values
`define OFS_STATUS 12'h000
`define OFS_CTRL 12'h004
`define OFS_SETUP_LO 12'h008
`define OFS_SETUP_HI 12'h00C
`define OFS_WDOG 12'h010
`define SETUP_RST 8'h00
`define IDENT_VAL 8'h5A // arbitrary identity value
`endif

// *** shared/mscd_pkg.sv ***
/*
  Types of the serial command decoder.
  Assumes the constant header is on the include path.
*/
`include "mscd_map.svh"
package mscd_pkg;
  typedef logic [7:0] mscd_byte_t;
  typedef enum logic [1:0] {UP_IDLE, UP_SEND, UP_GAP} mscd_up_e;
  typedef struct packed {
    logic cl_s1, cl_s2, cl_q, dt_s1, dt_s2, en_s1, en_s2;
    logic [3:0] bit_cnt;
    logic [14:0] shift;
    logic [6:0][7:0] setup;
    mscd_byte_t par_cfg, answer, window;
    logic [13:0] out_ctrl, stage;
    logic outs_off, frozen, relay_on, swrst, par_mode;
    mscd_up_e up_st;
    logic [2:0] up_blk, pend_blk;
    logic up_single, pend, pend_single;
    logic [5:0] up_addr, pend_addr;
    logic [1:0] up_slot;
    logic [3:0] up_bit;
    logic [4:0] up_tick;
    logic [15:0] up_word;
    logic up_line;
    logic [31:0] prdata;
    logic pready, pslverr;
  } mscd_state_s;
endpackage : mscd_pkg

// *** verilog/mscd_decoder.sv ***
/*
  Command decoder of the downstream serial link, upstream burst sender,
  setup store, freeze and output-disable control, APB status and control.
  Assumes link pins are asynchronous and power logic shares clock.
*/
`include "mscd_map.svh"
module mscd_decoder
  import mscd_pkg::*;
#(
  parameter mscd_byte_t IDENT = `IDENT_VAL // arbitrary identity value
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // downstream link
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_en_n,
  // upstream link
  output logic up_data,
  // sources of read data, relay trip input
  input wire mscd_byte_t [11:0] diag_regs,
  input wire mscd_byte_t wd_question,
  input wire mscd_byte_t step_hi,
  input wire mscd_byte_t step_lo,
  input wire mscd_byte_t req_lo,
  input wire mscd_byte_t req_hi,
  input wire mscd_byte_t rst_count,
  input wire logic ovc_trip,
  // controls out
  output logic [13:0] stage_drive,
  output logic output_disable,
  output logic main_relay_on,
  output logic soft_reset_pulse,
  output logic [6:0][7:0] setup_out,
  output mscd_byte_t par_setup,
  output mscd_byte_t answer_out,
  output mscd_byte_t window_out,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  //////////////////////////////////////////////////////////////////////////
  localparam mscd_state_s RST_S = '{outs_off: 1'b1, up_st: UP_IDLE, default: '0};

  mscd_state_s s, n;
  logic cl_fall, frame_done, sel, cmd_go, dat_go, cmd_bad, tick_end;
  logic wr_setup, rd_req, rd_single, load;
  logic [14:0] fb;
  logic [5:0] code;
  mscd_byte_t cdat;
  logic [2:0] wr_idx, rd_blk;

  // payload byte for a block slot or a single address
  function automatic mscd_byte_t pick(input logic [2:0] b, input logic single,
                                      input logic [5:0] a, input logic [1:0] k);
    mscd_byte_t [3:0] row;
    mscd_byte_t v;
    row = '0;
    v = '0;
    if (single) begin
      // (R24) single address map
      unique case (a)
        6'h03: v = s.setup[0];
        6'h05: v = s.setup[1];
        6'h06: v = s.setup[2];
        6'h09: v = s.setup[3];
        6'h0A: v = s.setup[4];
        6'h0C: v = s.setup[5];
        6'h0F: v = s.setup[6];
        6'h39: v = s.answer;
        6'h3A: v = s.window;
        6'h3C: v = s.par_cfg;
        6'h11: v = diag_regs[0];
        6'h12: v = diag_regs[1];
        6'h14: v = diag_regs[2];
        6'h17: v = diag_regs[3];
        6'h18: v = diag_regs[4];
        6'h1B: v = diag_regs[5];
        6'h1D: v = diag_regs[6];
        6'h1E: v = diag_regs[7];
        6'h21: v = diag_regs[8];
        6'h22: v = diag_regs[9];
        6'h24: v = diag_regs[10];
        6'h28: v = step_hi;
        6'h2B: v = step_lo;
        6'h2E: v = IDENT;
        6'h2D: v = diag_regs[11];
        6'h30: v = s.window;
        6'h33: v = req_lo;
        6'h35: v = req_hi;
        6'h36: v = rst_count;
        default: v = '0;
      endcase
    end else begin
      unique case (b)
        // (R7) block one order
        3'h0: row = {s.setup[3], s.setup[2], s.setup[1], s.setup[0]};
        // (R8) block two order
        3'h1: row = {8'h00, s.setup[6], s.setup[5], s.setup[4]};
        // (R9) diagnostic blocks ascending
        3'h2: row = {diag_regs[3], diag_regs[2], diag_regs[1], diag_regs[0]};
        3'h3: row = {diag_regs[7], diag_regs[6], diag_regs[5], diag_regs[4]};
        // (R10) block five with identity
        3'h4: row = {IDENT, diag_regs[10], diag_regs[9], diag_regs[8]};
        // (R11) block six order
        3'h5: row = {step_lo, step_hi, 8'h00, wd_question};
        // (R12) block seven order
        3'h6: row = {s.window, s.answer, diag_regs[11], diag_regs[11]};
        // (R13) block eight order
        3'h7: row = {rst_count, req_hi, req_lo, s.window};
      endcase
      v = row[k];
    end
    return v;
  endfunction : pick

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    fb = s.shift;
    frame_done = 1'b0;
    wr_setup = 1'b0;
    wr_idx = 3'h0;
    rd_req = 1'b0;
    rd_single = 1'b0;
    rd_blk = 3'h0;
    cmd_bad = 1'b0;
    load = 1'b0;
    n.swrst = 1'b0;
    // link synchronisers
    n.cl_s1 = link_clk;
    n.cl_s2 = s.cl_s1;
    n.cl_q = s.cl_s2;
    n.dt_s1 = link_data;
    n.dt_s2 = s.dt_s1;
    n.en_s1 = link_en_n;
    n.en_s2 = s.en_s1;
    cl_fall = s.cl_q & ~s.cl_s2;
    // (R3) shift in least significant bit first
    if (s.en_s2) begin
      n.bit_cnt = 4'h0;
    end else if (cl_fall && s.bit_cnt != `FRAME_BITS) begin
      n.shift = {s.dt_s2, s.shift[14:1]};
      n.bit_cnt = s.bit_cnt + 4'h1;
      frame_done = (s.bit_cnt == `FRAME_BITS - 4'h1);
      fb = n.shift;
    end
    // (R2) select bit, code, data byte
    sel = fb[0];
    code = fb[6:1];
    cdat = fb[14:7];
    cmd_go = frame_done & sel;
    dat_go = frame_done & ~sel;
    // (R1) distinct six bit codes
    if (cmd_go) begin
      unique case (code)
        // (R4) block reads, data ignored (R14)
        `CMD_RD1: begin rd_req = 1'b1; rd_blk = 3'h0; end
        `CMD_RD2: begin rd_req = 1'b1; rd_blk = 3'h1; end
        `CMD_RD3: begin rd_req = 1'b1; rd_blk = 3'h2; end
        `CMD_RD4: begin rd_req = 1'b1; rd_blk = 3'h3; end
        `CMD_RD5: begin rd_req = 1'b1; rd_blk = 3'h4; end
        `CMD_RD6: begin rd_req = 1'b1; rd_blk = 3'h5; end
        `CMD_RD7: begin rd_req = 1'b1; rd_blk = 3'h6; end
        `CMD_RD8: begin rd_req = 1'b1; rd_blk = 3'h7; end
        // (R5) setup writes
        `CMD_WR1: begin wr_setup = 1'b1; wr_idx = 3'h0; end
        `CMD_WR2: begin wr_setup = 1'b1; wr_idx = 3'h1; end
        `CMD_WR3: begin wr_setup = 1'b1; wr_idx = 3'h2; end
        `CMD_WR4: begin wr_setup = 1'b1; wr_idx = 3'h3; end
        `CMD_WR5: begin wr_setup = 1'b1; wr_idx = 3'h4; end
        `CMD_WR6: begin wr_setup = 1'b1; wr_idx = 3'h5; end
        `CMD_WR7: begin wr_setup = 1'b1; wr_idx = 3'h6; end
        // (R18) answer and window never frozen
        `CMD_ANSWER: n.answer = cdat;
        `CMD_WINDOW: n.window = cdat;
        `CMD_PARALLEL: if (s.par_mode && !s.frozen) n.par_cfg = cdat;
        // (R6) (R17) freeze and release
        `CMD_FREEZE: n.frozen = 1'b1;
        `CMD_RELEASE: n.frozen = 1'b0;
        // (R20) software reset
        `CMD_SWRST: begin
          n.swrst = 1'b1;
          n.setup = '0;
          n.par_cfg = `SETUP_RST;
          n.out_ctrl = '0;
          n.outs_off = 1'b1;
          n.frozen = 1'b0;
        end
        // (R21) start and stop
        `CMD_START: n.outs_off = 1'b0;
        `CMD_STOP: begin n.outs_off = 1'b1; n.out_ctrl = '0; end
        // (R24) single read, top bits must be zero
        `CMD_SINGLE: begin
          rd_req = (cdat[7:6] == 2'h0);
          rd_single = 1'b1;
        end
        // (R23) main relay rearm
        `CMD_REARM: n.relay_on = 1'b1;
        // (R25) unknown code ignored
        default: cmd_bad = 1'b1;
      endcase
    end
    // (R16) (R17) load unless frozen
    if (wr_setup && !s.frozen) n.setup[wr_idx] = cdat;
    // (R22) output frames ignored while disabled
    if (dat_go && !s.outs_off) n.out_ctrl = fb[14:1];
    n.stage = s.outs_off ? '0 : s.out_ctrl;
    if (ovc_trip) n.relay_on = 1'b0;
    // upstream sender
    tick_end = (s.up_tick == 5'(`UP_BIT_CYC - 1));
    if (s.up_st != UP_IDLE) n.up_tick = tick_end ? 5'h0 : s.up_tick + 5'h1;
    unique case (s.up_st)
      UP_IDLE: begin
        n.up_line = 1'b0;
        if (rd_req) begin
          n.up_blk = rd_blk;
          n.up_single = rd_single;
          n.up_addr = cdat[5:0];
          n.up_slot = 2'h0;
          load = 1'b1;
        end
      end
      UP_SEND: if (tick_end) begin
        if (s.up_bit == `UP_LAST_BIT) begin
          n.up_st = UP_GAP;
          n.up_line = 1'b0;
        end else begin
          n.up_bit = s.up_bit + 4'h1;
          n.up_word = s.up_word >> 1;
          n.up_line = n.up_word[0];
        end
      end
      UP_GAP: if (tick_end) begin
        // (R15) new burst after the gap bit
        if (s.pend) begin
          n.pend = 1'b0;
          n.up_blk = s.pend_blk;
          n.up_single = s.pend_single;
          n.up_addr = s.pend_addr;
          n.up_slot = 2'h0;
          load = 1'b1;
        end else if (!s.up_single && s.up_slot != `LAST_SLOT) begin
          n.up_slot = s.up_slot + 2'h1;
          load = 1'b1;
        end else begin
          n.up_st = UP_IDLE;
        end
      end
    endcase
    if (load) begin
      n.up_word[4:0] = {n.up_slot, 2'h0, 1'b1};
      n.up_word[12:5] = pick(n.up_blk, n.up_single, n.up_addr, n.up_slot);
      n.up_word[13] = ^n.up_word[12:5];
      n.up_word[15:14] = 2'h0;
      n.up_st = UP_SEND;
      n.up_bit = 4'h0;
      n.up_tick = 5'h0;
      n.up_line = 1'b1;
    end
    // (R15) request during a burst is held
    if (rd_req && s.up_st != UP_IDLE) begin
      n.pend = 1'b1;
      n.pend_blk = rd_blk;
      n.pend_single = rd_single;
      n.pend_addr = cdat[5:0];
    end
    if (n.swrst) begin
      n.up_st = UP_IDLE;
      n.pend = 1'b0;
      n.up_line = 1'b0;
    end
    // apb slave
    n.pready = psel & ~penable;
    if (psel && !penable) begin
      n.pslverr = 1'b0;
      unique case (paddr)
        `OFS_STATUS: n.prdata = {27'h0, s.relay_on, s.pend, s.up_st != UP_IDLE,
                                 s.frozen, s.outs_off};
        `OFS_CTRL: n.prdata = {31'h0, s.par_mode};
        `OFS_SETUP_LO: n.prdata = {s.setup[3], s.setup[2], s.setup[1], s.setup[0]};
        `OFS_SETUP_HI: n.prdata = {s.par_cfg, s.setup[6], s.setup[5], s.setup[4]};
        `OFS_WDOG: n.prdata = {16'h0, s.window, s.answer};
        default: begin n.prdata = '0; n.pslverr = 1'b1; end
      endcase
    end
    if (psel && penable && s.pready && pwrite && paddr == `OFS_CTRL) n.par_mode = pwdata[0];
  end

  //////////////////////////////////////////////////////////////////////////
  // (R19) reset leaves writes released
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  assign up_data = s.up_line;
  assign stage_drive = s.stage;
  assign output_disable = s.outs_off;
  assign main_relay_on = s.relay_on;
  assign soft_reset_pulse = s.swrst;
  assign setup_out = s.setup;
  assign par_setup = s.par_cfg;
  assign answer_out = s.answer;
  assign window_out = s.window;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;

  //////////////////////////////////////////////////////////////////////////
  a_start_clear: assert property (@(posedge clock) disable iff (rst) // (R21)
    cmd_go && code == `CMD_START |=> !s.outs_off ##1 (!s.outs_off || $past(cmd_go)))
    else $error("start left outputs disabled");
  a_stop_set: assert property (@(posedge clock) disable iff (rst) // (R21)
    cmd_go && code == `CMD_STOP |=> s.outs_off ##1 s.stage == '0)
    else $error("stop did not disable outputs");
  a_write_load: assert property (@(posedge clock) disable iff (rst) // (R16)
    wr_setup && !s.frozen |=> s.setup[$past(wr_idx)] == $past(cdat))
    else $error("setup write not loaded");
  a_freeze_hold: assert property (@(posedge clock) disable iff (rst) // (R17)
    (wr_setup || code == `CMD_PARALLEL) && cmd_go && s.frozen |=>
      $stable(s.setup) && $stable(s.par_cfg))
    else $error("frozen setup changed");
  a_answer_free: assert property (@(posedge clock) disable iff (rst) // (R18)
    cmd_go && code == `CMD_ANSWER |=> s.answer == $past(cdat))
    else $error("answer write blocked");
  a_soft_reset: assert property (@(posedge clock) disable iff (rst) // (R20)
    cmd_go && code == `CMD_SWRST |=>
      s.setup == '0 && s.outs_off && !s.frozen && s.up_st == UP_IDLE)
    else $error("software reset incomplete");
  a_disable_off: assert property (@(posedge clock) disable iff (rst) // (R22)
    dat_go && s.outs_off |=> $stable(s.out_ctrl) ##1 s.stage == '0)
    else $error("output frame taken while disabled");
  a_unknown_quiet: assert property (@(posedge clock) disable iff (rst) // (R25)
    cmd_bad && s.up_st == UP_IDLE |=>
      s.up_st == UP_IDLE && $stable(s.setup) && $stable(s.outs_off))
    else $error("unknown code had an effect");
  a_burst_swap: assert property (@(posedge clock) disable iff (rst) // (R15)
    s.up_st == UP_GAP && tick_end && s.pend && !rd_req && !n.swrst |=>
      s.up_st == UP_SEND && s.up_slot == 2'h0 && s.up_blk == $past(s.pend_blk) && !s.pend)
    else $error("pending burst not started after gap");
  a_burst_len: assert property (@(posedge clock) disable iff (rst) // (R7)
    s.up_st == UP_GAP && tick_end && !s.pend && !s.up_single && s.up_slot == `LAST_SLOT
      && !n.swrst |=> s.up_st == UP_IDLE)
    else $error("burst longer than four frames");

endmodule : mscd_decoder

// *** tb/mscd_master.sv ***
/*
  Controller model: sends downstream command frames, captures upstream frames.
  Assumes the bench clock and a decoder on the far side of the link.
*/
module mscd_master (
  // clock
  input wire logic clock,
  // downstream link
  output logic link_clk,
  output logic link_data,
  output logic link_en_n,
  // upstream link
  input wire logic up_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] w;
  logic [15:0] rx_q[$];
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
    link_en_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // frame, lsb first
  task automatic send(input logic [14:0] f);
    @(posedge clock);
    link_en_n <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      repeat (4) @(posedge clock);
      link_clk <= 1'b1;
      link_data <= f[i];
      repeat (4) @(posedge clock);
      link_clk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    link_en_n <= 1'b1;
    link_data <= ~f[14];
    repeat (8) @(posedge clock);
  endtask : send
  ////////////////////////////////////////////////////////////
  // upstream capture, mid-bit sampling
  initial begin
    forever begin
      @(posedge clock iff up_data === 1'b1);
      repeat (7) @(posedge clock);
      for (int i = 0; i < 16; i++) begin
        w[i] = up_data;
        repeat (16) @(posedge clock);
      end
      rx_q.push_back(w);
    end
  end
endmodule : mscd_master

// *** tb/msc_command_decoder_bench.sv ***
/*
  Self-checking bench of the command decoder: link frames, bursts, APB.
  Assumes the decoder assertions live in the design files.
*/
`include "mscd_map.svh"
module msc_command_decoder_bench
  import mscd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam mscd_byte_t ID = 8'h3C; // arbitrary identity value
  logic clock, rst, link_clk, link_data, link_en_n, up_data, ovc_trip;
  logic output_disable, main_relay_on, soft_reset_pulse, err;
  logic srp_seen = 1'b0;
  mscd_byte_t [11:0] diag_regs;
  mscd_byte_t wd_question, step_hi, step_lo, req_lo, req_hi, rst_count;
  mscd_byte_t par_setup, answer_out, window_out, sb, v;
  logic [13:0] stage_drive;
  logic [6:0][7:0] setup_out;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [8:0] e;
  int n_fail, checks;
  logic [5:0] wc[9] = '{`CMD_WR1, `CMD_WR2, `CMD_WR3, `CMD_WR4, `CMD_WR5, `CMD_WR6,
    `CMD_WR7, `CMD_ANSWER, `CMD_WINDOW};
  logic [5:0] rc[8] = '{`CMD_RD1, `CMD_RD2, `CMD_RD3, `CMD_RD4, `CMD_RD5, `CMD_RD6,
    `CMD_RD7, `CMD_RD8};
  mscd_decoder #(.IDENT(ID)) mscd_decoder_i (.clock, .rst, .link_clk, .link_data,
    .link_en_n, .up_data, .diag_regs, .wd_question, .step_hi, .step_lo, .req_lo,
    .req_hi, .rst_count, .ovc_trip, .stage_drive, .output_disable, .main_relay_on,
    .soft_reset_pulse, .setup_out, .par_setup, .answer_out, .window_out, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  mscd_master mscd_master_i (.clock, .link_clk, .link_data, .link_en_n, .up_data);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) if (soft_reset_pulse === 1'b1) srp_seen <= 1'b1;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [5:0] c, input logic [7:0] d);
    mscd_master_i.rx_q.delete();
    mscd_master_i.send({d, c, 1'b1});
  endtask : cmd
  task automatic get(input int n);
    for (int k = 0; k < 5000 && mscd_master_i.rx_q.size() < n; k++) @(posedge clock);
    repeat (400) @(posedge clock);
    chk("frame count", n, mscd_master_i.rx_q.size());
  endtask : get
  task automatic set_src(input logic [7:0] b);
    @(posedge clock);
    sb <= b;
    for (int i = 0; i < 12; i++) diag_regs[i] <= b + i[7:0];
    wd_question <= b + 8'h20;
    step_hi <= b + 8'h21;
    step_lo <= b + 8'h22;
    req_lo <= b + 8'h23;
    req_hi <= b + 8'h24;
    rst_count <= b + 8'h25;
  endtask : set_src
  function automatic logic [15:0] uf(input logic [1:0] s, input logic [7:0] d);
    return {2'b00, ^d, d, s, 2'b00, 1'b1};
  endfunction : uf
  function automatic logic [8:0] eb(input int b, input int s);
    logic [7:0] k;
    k = s[7:0];
    case (b)
      1: return {1'b1, 8'hA1 + k};
      2: return {s < 3, 8'hA5 + k};
      3: return {1'b1, sb + k};
      4: return {1'b1, sb + 8'h04 + k};
      5: return (s < 3) ? {1'b1, sb + 8'h08 + k} : {1'b1, ID};
      6: return (s == 0) ? {1'b1, sb + 8'h20} : {s > 1, sb + 8'h1F + k};
      7: return (s < 2) ? {1'b1, sb + 8'h0B} : {1'b1, 8'hB6 + k};
      default: return (s == 0) ? 9'h1B9 : {1'b1, sb + 8'h22 + k};
    endcase
  endfunction : eb
  function automatic logic [7:0] obs(input int i);
    return (i < 7) ? setup_out[i] : ((i == 7) ? answer_out : window_out);
  endfunction : obs
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ovc_trip = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    diag_regs = '0;
    {wd_question, step_hi, step_lo, req_lo, req_hi, rst_count} = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    chk("output_disable_bit", 1'b1, output_disable);
    chk("stages", 14'h0, stage_drive);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status", 32'h1, q);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      v = (i < 7) ? 8'hA1 + i[7:0] : 8'hB1 + i[7:0];
      cmd(wc[i], v);
      chk("write row", v, obs(i));
    end
    $display("test writes done");
    for (int b = 1; b <= 8; b++) begin
      set_src(8'h10 * b[7:0]);
      cmd(rc[b-1], b[0] ? 8'hFF : 8'h00);
      get(4);
      for (int s = 0; s < 4; s++) begin
        e = eb(b, s);
        if (e[8]) chk("block", uf(s[1:0], e[7:0]), mscd_master_i.rx_q[s]);
        else chk("unused slot", s, mscd_master_i.rx_q[s][4:3]);
      end
    end
    $display("test blocks done");
    cmd(`CMD_RD3, 8'h00);
    mscd_master_i.send({8'h00, `CMD_RD4, 1'b1});
    get(5);
    chk("cut burst", uf(2'h0, sb), mscd_master_i.rx_q[0]);
    for (int s = 0; s < 4; s++) begin
      chk("new burst", uf(s[1:0], sb + 8'h04 + s[7:0]), mscd_master_i.rx_q[s+1]);
    end
    cmd(`CMD_SINGLE, 8'h03);
    get(1);
    chk("single", uf(2'h0, 8'hA1), mscd_master_i.rx_q[0]);
    cmd(`CMD_SINGLE, 8'hC3);
    get(0);
    cmd(6'h00, 8'h55);
    get(0);
    chk("unknown", 8'hA1, setup_out[0]);
    $display("test reads done");
    cmd(`CMD_FREEZE, 8'hFF);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("frozen", 1'b1, q[1]);
    cmd(`CMD_WR1, 8'h3C);
    chk("locked", 8'hA1, setup_out[0]);
    cmd(`CMD_ANSWER, 8'h77);
    chk("answer", 8'h77, answer_out);
    cmd(`CMD_RELEASE, 8'h00);
    cmd(`CMD_WR1, 8'h3C);
    chk("released", 8'h3C, setup_out[0]);
    cmd(`CMD_PARALLEL, 8'h66);
    chk("par off", 8'h00, par_setup);
    apb(1'b1, `OFS_CTRL, 32'h1);
    cmd(`CMD_PARALLEL, 8'h66);
    chk("par on", 8'h66, par_setup);
    apb(1'b0, `OFS_SETUP_HI, 32'h0);
    chk("setup hi", 32'h66A7A6A5, q);
    apb(1'b0, `OFS_SETUP_LO, 32'h0);
    chk("setup lo", 32'hA4A3A23C, q);
    apb(1'b0, `OFS_WDOG, 32'h0);
    chk("wdog", 32'h0000B977, q);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 1'b1, err);
    $display("test freeze done");
    mscd_master_i.send({14'h2A5B, 1'b0});
    chk("stage off", 14'h0, stage_drive);
    cmd(`CMD_START, 8'h81);
    chk("start", 1'b0, output_disable);
    mscd_master_i.send({14'h2A5B, 1'b0});
    chk("stage on", 14'h2A5B, stage_drive);
    cmd(`CMD_STOP, 8'h18);
    chk("stop", 1'b1, output_disable);
    chk("stage stop", 14'h0, stage_drive);
    cmd(`CMD_REARM, 8'hAA);
    chk("rearm", 1'b1, main_relay_on);
    @(posedge clock);
    ovc_trip <= 1'b1;
    repeat (2) @(posedge clock);
    ovc_trip <= 1'b0;
    repeat (2) @(posedge clock);
    chk("trip", 1'b0, main_relay_on);
    $display("test outputs done");
    cmd(`CMD_START, 8'h00);
    cmd(`CMD_SWRST, 8'h5A);
    chk("soft pulse", 1'b1, srp_seen);
    chk("setup clear", `SETUP_RST, setup_out[0]);
    chk("par clear", 8'h00, par_setup);
    chk("drivers off", 1'b1, output_disable);
    $display("test soft reset done");
    end_sim();
  end
endmodule : msc_command_decoder_bench
